/* File: hdl/pcsyn_top.sv */
// Purpose: pixel clock source select, prescaler, phase comparator and sound clock
// Assumes: all clock pins are sampled as synchronous inputs of aclk (25 MHz)
// Notes:   AXI4-Lite slave; comparator pin is split into value and enable
//
// Overview of operation
// - video control bits 1:0 pick the pixel clock source
// - selected pixel clock divided by 1 to 8 from video control bits 4:2
// - candidates are high-frequency input, vco input, internal 32 MHz reference
// - comparator fed only by vco input and internal reference
// - sound clock from reference or sound clock input, then halved
// - two preloadable down counters, reference and vco, moduli from synth register
// - synth bit 6 forces output high driven unless bit 14 is set, bit 14 forces low driven
// - synth bit 7 holds reference counter clear, bit 15 holds vco counter clear
// - output mostly tristate, high to raise vco, low to lower it
// - in lock vco equals reference times vco modulus over reference modulus
// - each counter's modulus is its programmed value plus one
// - inverted vco output is the logical inversion of the vco input
//
// Design decisions made here: the register addresses and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none

module pcsyn_top
	import pcsyn_pkg::*;
(
	input  wire logic        aclk,
	input  wire logic        aresetn,
	input  wire logic        ce,
	input  wire logic [31:0] s_axi_awaddr,
	input  wire logic        s_axi_awvalid,
	output logic             s_axi_awready,
	input  wire logic [31:0] s_axi_wdata,
	input  wire logic [3:0]  s_axi_wstrb,
	input  wire logic        s_axi_wvalid,
	output logic             s_axi_wready,
	output logic [1:0]       s_axi_bresp,
	output logic             s_axi_bvalid,
	input  wire logic        s_axi_bready,
	input  wire logic [31:0] s_axi_araddr,
	input  wire logic        s_axi_arvalid,
	output logic             s_axi_arready,
	output logic [31:0]      s_axi_rdata,
	output logic [1:0]       s_axi_rresp,
	output logic             s_axi_rvalid,
	input  wire logic        s_axi_rready,
	input  wire logic        hf_clock_input,
	input  wire logic        vco_clock_input,
	input  wire logic        io_clock_input,
	input  wire logic        sound_clock_input,
	output logic             vco_clock_inverted_output,
	output logic             pixel_clock_tick,
	output logic             sound_clock_output,
	output logic             phase_compare_output,
	output logic             phase_compare_output_oe
);

	// ----------------------------------------------------------------
	// registers and internal state
	// ----------------------------------------------------------------
	pcsyn_vc_t          vc;
	pcsyn_synth_t       syn;
	pcsyn_pfd_t         pfd;
	pcsyn_pfd_t         next_pfd;
	logic [31:0]        aw_addr;
	logic               aw_full;
	logic [31:0]        w_data;
	logic [3:0]         w_strb;
	logic               w_full;
	logic [MOD_W-1:0]   r_count;
	logic [MOD_W-1:0]   v_count;
	logic               r_tc;
	logic               v_tc;
	logic [2:0]         pre_count;
	logic               hf_q;
	logic               vco_q;
	logic               ref_clock_32m;
	logic               snd_in_q;
	logic               hf_rise;
	logic               vco_rise;
	logic               ref_rise;
	logic               snd_in_rise;
	logic               sel_rise;
	logic               snd_rise;
	logic               comparator_ref_clock;
	logic [3:0]         wr_off;
	logic [3:0]         rd_off;
	logic               wr_fire;

	// ----------------------------------------------------------------
	// clock pin sampling and edge detection
	// ----------------------------------------------------------------
	// the reference is the sampled io clock; no further division here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hf_q          <= 1'b0;
			vco_q         <= 1'b0;
			ref_clock_32m <= 1'b0;
			snd_in_q      <= 1'b0;
		end else if (ce) begin
			hf_q          <= hf_clock_input;
			vco_q         <= vco_clock_input;
			ref_clock_32m <= io_clock_input;
			snd_in_q      <= sound_clock_input;
		end
	end

	assign hf_rise              = hf_clock_input & ~hf_q;
	assign vco_rise             = vco_clock_input & ~vco_q;
	assign ref_rise             = io_clock_input & ~ref_clock_32m;
	assign snd_in_rise          = sound_clock_input & ~snd_in_q;
	assign comparator_ref_clock = ref_rise;

	// a plain wire, so the external bias resistor sees no added delay
	assign vco_clock_inverted_output = ~vco_clock_input;

	// ----------------------------------------------------------------
	// pixel source select and prescaler
	// ----------------------------------------------------------------
	always_comb begin
		case (vc.pix_sel)
			PIX_SRC_HF:  sel_rise = hf_rise;
			PIX_SRC_VCO: sel_rise = vco_rise;
			PIX_SRC_REF: sel_rise = ref_rise;
			default:     sel_rise = ref_rise;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pre_count        <= 3'h0;
			pixel_clock_tick <= 1'b0;
		end else if (ce) begin
			pixel_clock_tick <= 1'b0;
			if (sel_rise) begin
				if (pre_count >= vc.prescale) begin
					pre_count        <= 3'h0;
					pixel_clock_tick <= 1'b1;
				end else begin
					pre_count <= pre_count + 3'h1;
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// sound clock
	// ----------------------------------------------------------------
	assign snd_rise = vc.snd_sel ? snd_in_rise : ref_rise;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			sound_clock_output <= 1'b0;
		end else if (ce && snd_rise) begin
			sound_clock_output <= ~sound_clock_output;
		end
	end

	// ----------------------------------------------------------------
	// modulus counters
	// ----------------------------------------------------------------
	// counting from value down to zero spans value plus one input edges
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			r_count <= '0;
		end else if (ce) begin
			if (syn.r_clear) begin
				r_count <= '0;
			end else if (comparator_ref_clock) begin
				if (r_count == '0) begin
					r_count <= syn.r_mod;
				end else begin
					r_count <= r_count - 1'b1;
				end
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			v_count <= '0;
		end else if (ce) begin
			if (syn.v_clear) begin
				v_count <= '0;
			end else if (vco_rise) begin
				if (v_count == '0) begin
					v_count <= syn.v_mod;
				end else begin
					v_count <= v_count - 1'b1;
				end
			end
		end
	end

	assign r_tc = comparator_ref_clock && !syn.r_clear && (r_count == '0);
	assign v_tc = vco_rise && !syn.v_clear && (v_count == '0);

	// ----------------------------------------------------------------
	// phase detector
	// ----------------------------------------------------------------
	// reference ahead of vco pumps up until the vco event; the loop then
	// settles where both events are equally frequent
	always_comb begin
		case (pfd)
			PFD_HOLD: begin
				if (r_tc && !v_tc) begin
					next_pfd = PFD_UP;
				end else if (v_tc && !r_tc) begin
					next_pfd = PFD_DOWN;
				end else begin
					next_pfd = PFD_HOLD;
				end
			end
			PFD_UP:   next_pfd = v_tc ? PFD_HOLD : PFD_UP;
			PFD_DOWN: next_pfd = r_tc ? PFD_HOLD : PFD_DOWN;
			default:  next_pfd = PFD_HOLD;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pfd <= PFD_HOLD;
		end else if (ce) begin
			pfd <= next_pfd;
		end
	end

	// force low wins if both force bits are set, to keep the vco falling
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			phase_compare_output    <= 1'b0;
			phase_compare_output_oe <= 1'b0;
		end else if (ce) begin
			if (syn.v_force_lo) begin
				phase_compare_output    <= 1'b0;
				phase_compare_output_oe <= 1'b1;
			end else if (syn.r_force_hi) begin
				phase_compare_output    <= 1'b1;
				phase_compare_output_oe <= 1'b1;
			end else begin
				phase_compare_output    <= (next_pfd == PFD_UP);
				phase_compare_output_oe <= (next_pfd != PFD_HOLD);
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite write path
	// ----------------------------------------------------------------
	// readies follow the enable, so a frozen cycle never swallows a beat
	assign s_axi_awready = ce && !aw_full && !s_axi_bvalid;
	assign s_axi_wready  = ce && !w_full && !s_axi_bvalid;
	assign wr_fire       = aw_full && w_full && !s_axi_bvalid;
	assign wr_off        = aw_addr[3:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_full      <= 1'b0;
			aw_addr      <= 32'h0000_0000;
			w_full       <= 1'b0;
			w_data       <= 32'h0000_0000;
			w_strb       <= 4'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_full <= 1'b1;
				aw_addr <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_full <= 1'b1;
				w_data <= s_axi_wdata;
				w_strb <= s_axi_wstrb;
			end
			if (wr_fire) begin
				aw_full      <= 1'b0;
				w_full       <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp  <= (aw_addr[31:4] == 28'h000_0000 && wr_off != OFF_STATUS &&
					wr_off[1:0] == 2'h0 && wr_off <= OFF_STATUS) ? RESP_OKAY : RESP_DECERR;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// test bits are expected only during test and power-up, not checked here
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			vc  <= pcsyn_vc_t'(VC_RESET);
			syn <= pcsyn_synth_t'(SYNTH_RESET);
		end else if (ce && wr_fire && aw_addr[31:4] == 28'h000_0000) begin
			if (wr_off == OFF_VIDEO_CTRL && w_strb[0]) begin
				vc <= pcsyn_vc_t'(w_data[5:0]);
			end
			if (wr_off == OFF_SYNTH_CTRL) begin
				if (w_strb[0]) begin
					syn[7:0] <= w_data[7:0];
				end
				if (w_strb[1]) begin
					syn[15:8] <= w_data[15:8];
				end
			end
		end
	end

	// ----------------------------------------------------------------
	// AXI4-Lite read path
	// ----------------------------------------------------------------
	assign s_axi_arready = ce && !s_axi_rvalid;
	assign rd_off        = s_axi_araddr[3:0];

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= RESP_OKAY;
		end else if (ce) begin
			if (s_axi_arvalid && s_axi_arready) begin
				s_axi_rvalid <= 1'b1;
				s_axi_rresp  <= RESP_OKAY;
				s_axi_rdata  <= 32'h0000_0000;
				if (s_axi_araddr[31:4] != 28'h000_0000 || rd_off[1:0] != 2'h0) begin
					s_axi_rresp <= RESP_DECERR;
				end else if (rd_off == OFF_VIDEO_CTRL) begin
					s_axi_rdata <= {26'h000_0000, vc};
				end else if (rd_off == OFF_STATUS) begin
					s_axi_rdata <= {14'h0000, v_count, 2'h0, r_count, pfd,
						phase_compare_output_oe, phase_compare_output};
				end else if (rd_off != OFF_SYNTH_CTRL) begin
					s_axi_rresp <= RESP_DECERR;
				end
			end else if (s_axi_rvalid && s_axi_rready) begin
				s_axi_rvalid <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);

	a_force_high_drive: assert property (
		ce && syn.r_force_hi && !syn.v_force_lo |=>
			phase_compare_output && phase_compare_output_oe)
		else $error("force high did not drive the comparator high");

	a_force_low_drive: assert property (
		ce && syn.v_force_lo |=> !phase_compare_output && phase_compare_output_oe)
		else $error("force low did not drive the comparator low");

	a_ref_clear_hold: assert property (
		ce && syn.r_clear |=> r_count == '0)
		else $error("reference counter not held clear");

	a_vco_clear_hold: assert property (
		ce && syn.v_clear |=> v_count == '0)
		else $error("vco counter not held clear");

	a_ref_reload_mod: assert property (
		ce && r_tc |=> r_count == $past(syn.r_mod))
		else $error("reference counter did not reload its modulus");

	a_vco_reload_mod: assert property (
		ce && v_tc |=> v_count == $past(syn.v_mod))
		else $error("vco counter did not reload its modulus");

	a_idle_tristate: assert property (
		ce && !syn.r_force_hi && !syn.v_force_lo && pfd == PFD_HOLD && !r_tc && !v_tc
			|=> !phase_compare_output_oe)
		else $error("comparator driven while detector idle");

	a_up_until_vco: assert property (
		ce && pfd == PFD_UP && !v_tc && !syn.r_force_hi && !syn.v_force_lo
			|=> phase_compare_output && phase_compare_output_oe)
		else $error("pump up released before vco event");

	a_prescale_tick: assert property (
		ce && sel_rise && pre_count >= vc.prescale |=> pixel_clock_tick)
		else $error("prescaler missed its terminal edge");

	a_sound_halve: assert property (
		ce && snd_rise |=> sound_clock_output != $past(sound_clock_output))
		else $error("sound clock did not toggle on source edge");

	a_bresp_holds: assert property (
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
		else $error("write response dropped before acceptance");

endmodule : pcsyn_top

`default_nettype wire

/* File: include/pcsyn_pkg.sv */
// Purpose: shared constants and types of the pixel clock synthesizer
// Assumes: 32-bit AXI4-Lite register bus, one aligned word per register
// Notes:   field layouts follow the register bit positions exactly
package pcsyn_pkg;

	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [3:0]  OFF_VIDEO_CTRL   = 4'h0;
	localparam logic [3:0]  OFF_SYNTH_CTRL   = 4'h4;
	localparam logic [3:0]  OFF_STATUS       = 4'h8;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int          VC_PIX_SEL_LSB   = 0;
	localparam int          VC_PRESCALE_LSB  = 2;
	localparam int          VC_SND_SEL_BIT   = 5;
	localparam int          SYN_R_MOD_LSB    = 0;
	localparam int          SYN_R_FORCE_HI   = 6;
	localparam int          SYN_R_CLEAR      = 7;
	localparam int          SYN_V_MOD_LSB    = 8;
	localparam int          SYN_V_FORCE_LO   = 14;
	localparam int          SYN_V_CLEAR      = 15;
	localparam logic [5:0]  VC_RESET         = 6'h00;
	localparam logic [15:0] SYNTH_RESET      = 16'h0000;
	localparam int          MOD_W            = 6;

	// ----------------------------------------------------------------
	// pixel source codes and bus answers
	// ----------------------------------------------------------------
	localparam logic [1:0]  PIX_SRC_HF       = 2'h0;
	localparam logic [1:0]  PIX_SRC_VCO      = 2'h1;
	localparam logic [1:0]  PIX_SRC_REF      = 2'h2;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_DECERR      = 2'h3;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef struct packed {
		logic             snd_sel;
		logic [2:0]       prescale;
		logic [1:0]       pix_sel;
	} pcsyn_vc_t;

	typedef struct packed {
		logic             v_clear;
		logic             v_force_lo;
		logic [MOD_W-1:0] v_mod;
		logic             r_clear;
		logic             r_force_hi;
		logic [MOD_W-1:0] r_mod;
	} pcsyn_synth_t;

	typedef enum logic [1:0] {
		PFD_HOLD = 2'b00,
		PFD_UP   = 2'b01,
		PFD_DOWN = 2'b11
	} pcsyn_pfd_t;

endpackage : pcsyn_pkg

/* File: bench/pcsyn_vco_model.sv */
// Purpose: behavioural loop filter and vco on the comparator pin
// Assumes: pump pin sampled on aclk, vco free running
// Notes:   period counted in aclk cycles; the filter reacts slowly
`timescale 1ns/1ps
`default_nettype none
module pcsyn_vco_model (
	input  wire logic aclk,
	input  wire logic pump,
	input  wire logic pump_oe,
	output logic      vco_out
);
	int half = 6;
	int cnt  = 0;
	int slow = 0;
	initial vco_out = 1'b0;
	always @(posedge aclk) begin
		slow <= slow + 1;
		// tristate leaves the filter voltage where it was
		if (pump_oe === 1'b1 && slow % 16 == 0) begin
			if (pump === 1'b1 && half > 1)
				half <= half - 1;
			else if (pump === 1'b0 && half < 40)
				half <= half + 1;
		end
		if (cnt >= half) begin
			cnt     <= 0;
			vco_out <= ~vco_out;
		end else
			cnt <= cnt + 1;
	end
endmodule : pcsyn_vco_model
`default_nettype wire

/* File: bench/pcsyn_top_tb.sv */
// Purpose: self-checking bench of the pixel clock synthesizer
// Assumes: ce high except one freeze window; pins toggled by the bench at slow rates
// Notes:   counts are compared with a small slack for phase
`timescale 1ns/1ps
`default_nettype none
module pcsyn_top_tb;
	import pcsyn_pkg::*;
	logic        aclk = 0, aresetn = 0;
	logic [31:0] awaddr = 0, wdata = 0, araddr = 0, d;
	logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0, ce = 1;
	logic        hf = 0, io = 0, snd = 0, src_prev = 0, ssrc_prev = 0, so_prev = 0;
	logic [1:0]  r;
	logic [5:0]  vc = 0;
	logic        awready, wready, bvalid, arready, rvalid, vco, vco_n, tick, so, pc, pc_oe;
	logic [1:0]  bresp, rresp;
	logic [31:0] rdata;
	int          cyc = 0, rises = 0, srises = 0, ticks = 0, toggles = 0;
	int          bad_count = 0, checked = 0, seed = 11, n;
	wire         src  = (vc[1:0] == PIX_SRC_HF) ? hf : (vc[1:0] == PIX_SRC_VCO) ? vco : io;
	wire         ssrc = vc[5] ? snd : io;

	always #20 aclk = ~aclk;

	pcsyn_top pcsyn_top_i (.aclk(aclk), .aresetn(aresetn), .ce(ce),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .hf_clock_input(hf),
		.vco_clock_input(vco), .io_clock_input(io), .sound_clock_input(snd),
		.vco_clock_inverted_output(vco_n), .pixel_clock_tick(tick),
		.sound_clock_output(so), .phase_compare_output(pc),
		.phase_compare_output_oe(pc_oe));

	pcsyn_vco_model pcsyn_vco_model_i (.aclk(aclk), .pump(pc), .pump_oe(pc_oe), .vco_out(vco));

	// ----------------------------------------------------------------
	// pin stimulus and monitors
	// ----------------------------------------------------------------
	// the io pin stands in for a scaled-down 32 MHz reference
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		hf  <= ~hf;
		if (cyc % 2 == 1) io <= ~io;
		if (cyc % 3 == 2) snd <= ~snd;
		src_prev  <= src;
		ssrc_prev <= ssrc;
		so_prev   <= so;
		if (src && !src_prev) rises++;
		if (ssrc && !ssrc_prev) srises++;
		if (tick === 1'b1) ticks++;
		if (so !== so_prev) toggles++;
	end

	// ----------------------------------------------------------------
	// checks and bus tasks
	// ----------------------------------------------------------------
	task check_val(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			bad_count++;
			$display("unexpected at %0t: got %h want %h", $time, got, exp);
		end
	endtask : check_val

	task check_near(input int got, input int exp);
		checked++;
		if (got > exp + 2 || got < exp - 2) begin
			bad_count++;
			$display("unexpected at %0t: count %0d want %0d", $time, got, exp);
		end
	endtask : check_near

	task axi_wr(input logic [31:0] a, input logic [31:0] v);
		logic aw_o, w_o, done;
		begin
			@(posedge aclk);
			awaddr <= a; wdata <= v; awvalid <= 1; wvalid <= 1; bready <= 1;
			aw_o = 1; w_o = 1; done = 0;
			// no cycle limit here: only the watchdog ends a hung wait
			while (!done) begin
				@(posedge aclk);
				if (aw_o && awready === 1'b1) begin awvalid <= 0; aw_o = 0; end
				if (w_o && wready === 1'b1) begin wvalid <= 0; w_o = 0; end
				if (bvalid === 1'b1) begin r = bresp; bready <= 0; done = 1; end
			end
		end
	endtask : axi_wr

	task axi_rd(input logic [31:0] a);
		logic done;
		begin
			@(posedge aclk);
			araddr <= a; arvalid <= 1; rready <= 1; done = 0;
			while (!done) begin
				@(posedge aclk);
				if (arready === 1'b1) arvalid <= 0;
				if (rvalid === 1'b1) begin d = rdata; r = rresp; rready <= 0; done = 1; end
			end
		end
	endtask : axi_rd

	task give_verdict;
		$display("checked %0d bad_count %0d", checked, bad_count);
		if (bad_count == 0 && checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : give_verdict

	initial begin
		#(40 * 30000);
		bad_count++;
		give_verdict();
	end

	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		int r0, s0, t0, g0, m;
		repeat (8) @(posedge aclk);
		aresetn <= 1;
		axi_rd(32'h0000_0000 | OFF_VIDEO_CTRL);
		check_val(d, 32'h0000_0000);
		axi_rd(32'h0000_0000 | OFF_SYNTH_CTRL);
		check_val(d, 32'h0000_0000);
		check_val({30'h0000_0000, r}, {30'h0000_0000, RESP_OKAY});
		axi_rd(32'h0000_000C);
		check_val({30'h0000_0000, r}, {30'h0000_0000, RESP_DECERR});
		axi_wr(32'h0000_0000 | OFF_STATUS, 32'hFFFF_FFFF);
		check_val({30'h0000_0000, r}, {30'h0000_0000, RESP_DECERR});
		// power-up: both counters cleared, forced low, r above v
		axi_wr(32'h0000_0000 | OFF_SYNTH_CTRL, 32'h0000_C490);
		check_val({30'h0000_0000, r}, {30'h0000_0000, RESP_OKAY});
		repeat (3) @(posedge aclk);
		check_val({30'h0000_0000, pc, pc_oe}, 32'h0000_0001);
		axi_rd(32'h0000_0000 | OFF_STATUS);
		check_val(d & 32'h0003_F3F0, 32'h0);
		axi_wr(32'h0000_0000 | OFF_SYNTH_CTRL, 32'h0000_0040);
		repeat (3) @(posedge aclk);
		check_val({30'h0000_0000, pc, pc_oe}, 32'h0000_0003);
		axi_wr(32'h0000_0000 | OFF_SYNTH_CTRL, 32'h0000_4040);
		repeat (3) @(posedge aclk);
		check_val({30'h0000_0000, pc, pc_oe}, 32'h0000_0001);
		// clearing does not reset the detector, so park it in hold first:
		// r alone pumps up, then one vco event with r held clear releases it
		axi_wr(32'h0000_0000 | OFF_SYNTH_CTRL, 32'h0000_8000);
		repeat (20) @(posedge aclk);
		check_val({30'h0000_0000, pc, pc_oe}, 32'h0000_0003);
		axi_wr(32'h0000_0000 | OFF_SYNTH_CTRL, 32'h0000_3F80);
		repeat (100) @(posedge aclk);
		// both held clear: no terminal events, the pin stays released
		axi_wr(32'h0000_0000 | OFF_SYNTH_CTRL, 32'h0000_8087);
		repeat (40) @(posedge aclk);
		check_val({31'h0000_0000, pc_oe}, 32'h0000_0000);
		// r released from zero: its first reference edge is already terminal
		axi_wr(32'h0000_0000 | OFF_SYNTH_CTRL, 32'h0000_8007);
		n = 0;
		while (pc_oe !== 1'b1 && n < 100) begin
			@(posedge aclk);
			n++;
		end
		check_near(n, 3);
		check_val({31'h0000_0000, pc}, 32'h0000_0001);
		// the reload value bounds the count: seven for a modulus of eight
		m = 0;
		repeat (24) begin
			axi_rd(32'h0000_0000 | OFF_STATUS);
			if (int'(d[9:4]) > m) m = int'(d[9:4]);
		end
		check_val(m, 32'h0000_0007);
		// real moduli kept under the test bits, then released
		axi_wr(32'h0000_0000 | OFF_SYNTH_CTRL, 32'h0000_C587);
		axi_wr(32'h0000_0000 | OFF_SYNTH_CTRL, 32'h0000_0507);
		for (int k = 0; k < 8; k++) begin
			vc[1:0] = k[1:0];
			vc[4:2] = (k == 0) ? 3'd0 : (k == 1) ? 3'd7 : 3'($random(seed));
			vc[5]   = k[2];
			axi_wr(32'h0000_0000 | OFF_VIDEO_CTRL, {26'h0, vc});
			axi_rd(32'h0000_0000 | OFF_VIDEO_CTRL);
			check_val(d, {26'h0, vc});
			repeat (8) @(posedge aclk);
			r0 = rises; s0 = srises; t0 = ticks; g0 = toggles;
			repeat (480) @(posedge aclk);
			check_near(ticks - t0, (rises - r0) / (vc[4:2] + 1));
			check_near(toggles - g0, srises - s0);
			check_val({31'h0000_0000, vco_n}, {31'h0000_0000, ~vco});
		end
		// a low enable freezes every state bit, the halved sound clock too
		ce <= 1'b0;
		@(posedge aclk);
		m = {31'h0000_0000, so};
		repeat (12) @(posedge aclk);
		check_val({31'h0000_0000, so}, m);
		ce <= 1'b1;
		give_verdict();
	end
endmodule : pcsyn_top_tb
`default_nettype wire
